/* hw/hbp_port.sv */
`timescale 1ns/10ps
`default_nettype none

module hbp_port
  import hbp_pkg::*;
(
  input wire logic clk, // 200 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire hbp_pins_t pins, // Host control pins
  input wire logic [HBP_DW-1:0] data_in, // Data bus input
  output logic [HBP_DW-1:0] data_out, // Data bus output
  output logic data_oe, // High while device drives data
  input wire logic [HBP_DW-1:0] reg_rdata, // Register read data
  input wire logic [HBP_DW-1:0] fifo_rdata, // Receive FIFO head word
  output hbp_req_t req // One-cycle access request
);

  // ----------------------------------------------------------------
  // State and decode nets
  // ----------------------------------------------------------------
  hbp_state_t s_q;
  hbp_state_t s_d;
  logic rd_qual;
  logic wr_qual;
  logic [HBP_DW-1:0] src_word;
  logic [HBP_DW-1:0] host_word;
  hbp_req_t req_hold;

  // Reset image of the whole state; the data bus starts released
  localparam hbp_state_t HBP_STATE_RST = '{
    phase: HBP_IDLE,
    req: '0,
    rdata: HBP_DATA_RST,
    data_oe: 1'b0
  };

  // ----------------------------------------------------------------
  // Byte order
  // ----------------------------------------------------------------
  // Host lanes are swapped in big-endian mode; internal words are little endian
  function automatic logic [HBP_DW-1:0] hbp_order(
    input logic [HBP_DW-1:0] w,
    input logic big
  );
    logic [HBP_DW-1:0] swapped;
    swapped = {w[HBP_LO_MSB:0], w[HBP_HI_MSB:HBP_HI_LSB]};
    return big ? swapped : w;
  endfunction

  // ----------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------
  // Chip select qualifies every strobe, so a strobe alone does nothing
  function automatic logic hbp_selected(
    input hbp_pins_t p
  );
    return !p.chip_select_n;
  endfunction

  function automatic logic hbp_read_qual(
    input hbp_pins_t p
  );
    return hbp_selected(p) && !p.read_strobe_n;
  endfunction

  // A read wins if the host drives both strobes low; a write there could
  // land stale data while the device is also driving the bus
  function automatic logic hbp_write_qual(
    input hbp_pins_t p
  );
    return hbp_selected(p) && !p.write_strobe_n && p.read_strobe_n;
  endfunction

  // ----------------------------------------------------------------
  // Address and source
  // ----------------------------------------------------------------
  // Direct-FIFO mode hides the address so no register is hit by accident
  function automatic logic [HBP_AW-1:0] hbp_req_addr(
    input hbp_pins_t p
  );
    return p.fifo_direct ? HBP_ADDR_RST : p.addr;
  endfunction

  function automatic logic [HBP_DW-1:0] hbp_source(
    input hbp_pins_t p,
    input logic [HBP_DW-1:0] reg_w,
    input logic [HBP_DW-1:0] fifo_w
  );
    return p.fifo_direct ? fifo_w : reg_w;
  endfunction

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  // Strobe pulses last one cycle; address and write data hold until the next access
  function automatic hbp_req_t hbp_idle_req(
    input hbp_req_t prev
  );
    hbp_req_t r;
    r = prev;
    r.reg_rd = 1'b0;
    r.reg_wr = 1'b0;
    r.fifo_pop = 1'b0;
    r.fifo_push = 1'b0;
    return r;
  endfunction

  function automatic hbp_req_t hbp_read_req(
    input hbp_req_t prev,
    input hbp_pins_t p
  );
    hbp_req_t r;
    r = hbp_idle_req(prev);
    r.fifo_pop = p.fifo_direct;
    r.reg_rd = !p.fifo_direct;
    r.addr = hbp_req_addr(p);
    return r;
  endfunction

  function automatic hbp_req_t hbp_write_req(
    input hbp_req_t prev,
    input hbp_pins_t p,
    input logic [HBP_DW-1:0] word
  );
    hbp_req_t r;
    r = hbp_idle_req(prev);
    r.fifo_push = p.fifo_direct;
    r.reg_wr = !p.fifo_direct;
    r.addr = hbp_req_addr(p);
    r.wdata = word;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  assign rd_qual = hbp_read_qual(pins);
  assign wr_qual = hbp_write_qual(pins);
  assign src_word = hbp_source(pins, reg_rdata, fifo_rdata);
  assign host_word = hbp_order(data_in, pins.big_endian);
  assign req_hold = hbp_idle_req(s_q.req);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Every access returns to idle before the next one counts, so the host
  // port spends one idle cycle between accesses
  always_comb begin
    s_d = s_q;
    s_d.req = req_hold;
    unique case (s_q.phase)
      HBP_IDLE: begin
        s_d.data_oe = 1'b0;
        if (rd_qual) begin
          // One pop or register read per strobe, issued on its leading edge
          s_d.phase = HBP_READ;
          s_d.req = hbp_read_req(s_q.req, pins);
        end else if (wr_qual) begin
          s_d.phase = HBP_WRITE;
        end
      end
      HBP_READ: begin
        // Data follows its source and the byte order while the strobe stands
        s_d.rdata = hbp_order(src_word, pins.big_endian);
        s_d.data_oe = rd_qual;
        if (!rd_qual) begin
          s_d.phase = HBP_IDLE;
        end
      end
      HBP_WRITE: begin
        // Data is captured at strobe release, where SRAM-style hosts hold it valid
        s_d.data_oe = 1'b0;
        if (!wr_qual) begin
          s_d.phase = HBP_IDLE;
          s_d.req = hbp_write_req(s_q.req, pins, host_word);
        end
      end
      default: begin
        // Unused phase code: fall back to idle with the bus released
        s_d.phase = HBP_IDLE;
        s_d.data_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Enable low freezes every field, so a request pulse stretches meanwhile
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= HBP_STATE_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from the state register
  assign data_out = s_q.rdata;
  assign data_oe = s_q.data_oe;
  assign req = s_q.req;

endmodule

`default_nettype wire

/* hw/hbp_pkg.sv */
package hbp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HBP_DW = 16;
  localparam int HBP_AW = 9;

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  localparam int HBP_LO_MSB = 7;
  localparam int HBP_HI_LSB = 8;
  localparam int HBP_HI_MSB = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] HBP_DATA_RST = 16'h0000;
  localparam logic [8:0] HBP_ADDR_RST = 9'h000;

  typedef enum logic [1:0] {
    HBP_IDLE,
    HBP_READ,
    HBP_WRITE
  } hbp_phase_t;

  // Host pins as seen by the device
  typedef struct packed {
    logic [HBP_AW-1:0] addr;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic fifo_direct;
    logic big_endian;
  } hbp_pins_t;

  // Internal request toward register file or data FIFOs
  typedef struct packed {
    logic reg_rd;
    logic reg_wr;
    logic fifo_pop;
    logic fifo_push;
    logic [HBP_AW-1:0] addr;
    logic [HBP_DW-1:0] wdata;
  } hbp_req_t;

  typedef struct packed {
    hbp_phase_t phase;
    hbp_req_t req;
    logic [HBP_DW-1:0] rdata;
    logic data_oe;
  } hbp_state_t;

endpackage

/* test/hbp_host_wire.sv */
`timescale 1ns/10ps
`default_nettype none
// Released bus shows the inverse of its last level, so a stale read cannot pass
module hbp_host_wire (
  input wire logic clk, // Clock
  input wire logic [15:0] data_out, // Device word
  input wire logic data_oe, // Device drives
  input wire logic [15:0] host_d, // Host word
  input wire logic host_oe, // Host drives
  output logic [15:0] bus // Wire level
);
  logic [15:0] last_q = '0;
  always_ff @(posedge clk) last_q <= bus;
  assign bus = data_oe ? data_out : host_oe ? host_d : ~last_q;
endmodule
`default_nettype wire

/* test/hbp_port_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module hbp_port_sva
  import hbp_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire hbp_pins_t pins, // Pins
  input wire logic [15:0] data_in, // Bus in
  input wire logic [15:0] data_out, // Bus out
  input wire logic data_oe, // Drive
  input wire logic [15:0] reg_rdata, // Reg word
  input wire logic [15:0] fifo_rdata, // Fifo word
  input wire hbp_req_t req // Request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] s_q;
  always_ff @(posedge clk) s_q <= pins.fifo_direct ? fifo_rdata : reg_rdata;
  wire logic q_rd = !pins.chip_select_n & !pins.read_strobe_n;
  chk_read_qual: assert property (req.reg_rd | req.fifo_pop |-> $past(q_rd)) else $error("bad read");
  chk_write_qual: assert property (req.reg_wr | req.fifo_push |->
    $past(!pins.chip_select_n & !pins.write_strobe_n, 2)) else $error("bad write");
  chk_write_data: assert property (req.reg_wr | req.fifo_push |->
    req.wdata == ($past(pins.big_endian) ? {$past(data_in[7:0]), $past(data_in[15:8])} : $past(data_in)))
    else $error("wdata");
  chk_pop_mode: assert property (req.fifo_pop |-> $past(pins.fifo_direct)) else $error("bad pop");
  chk_push_mode: assert property (req.fifo_push |-> $past(pins.fifo_direct)) else $error("bad push");
  chk_fifo_addr: assert property (req.fifo_pop | req.fifo_push |-> req.addr == 9'h000) else $error("addr");
  chk_reg_addr: assert property (req.reg_rd |-> req.addr == $past(pins.addr) && !$past(pins.fifo_direct))
    else $error("reg addr");
  chk_drive_gate: assert property (data_oe |-> $past(q_rd)) else $error("bad drive");
  chk_byte_order: assert property (data_oe && $past(data_oe) |->
    data_out == ($past(pins.big_endian) ? {s_q[7:0], s_q[15:8]} : s_q)) else $error("bad order");
endmodule
bind hbp_port hbp_port_sva chk (.*);
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hbp_pkg::*;
  logic clk = 0, rstn = 0, hoe = 0, oe, rd, wr, fd;
  logic [15:0] hd = '0, rr = '0, fr = '0, dout, bus, s;
  logic [31:0] r;
  logic [15:0] wq[$];
  hbp_pins_t pins = '1;
  hbp_req_t req;
  int errors = 0, samples_checked = 0, seed = 36, cyc = 0;
  always #2.5 clk = ~clk;
  hbp_port dut (.clk(clk), .rstn(rstn), .clk_en(1'b1), .pins(pins), .data_in(bus), .data_out(dout),
    .data_oe(oe), .reg_rdata(rr), .fifo_rdata(fr), .req(req));
  hbp_host_wire host (.clk(clk), .data_out(dout), .data_oe(oe), .host_d(hd), .host_oe(hoe), .bus(bus));
  task automatic chk(input logic [15:0] a, b);
    samples_checked++;
    if (a !== b) begin
      errors++;
      $display("MISMATCH %0t seen %h want %h", $time, a, b);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      r = $random(seed);
      // Test 40 is forced to a selected write and cut short by a reset
      if (i == 40) r[11:9] = 3'h0;
      // Select left high a quarter of the time so strobes must be ignored
      pins <= {r[8:0], r[9] & r[10], !r[11], r[11], r[12], r[13]};
      {hoe, hd} <= {!r[11], r[31:16]};
      {rr, fr} <= $random(seed);
      rd = r[11] & !(r[9] & r[10]);
      wr = !r[11] & !(r[9] & r[10]) & (i != 40);
      fd = r[12];
      if (wr) wq.push_back(r[13] ? {r[23:16], r[31:24]} : r[31:16]);
      @(posedge clk);
      @(negedge clk);
      chk(16'({req.reg_rd, req.fifo_pop}), 16'({rd & !fd, rd & fd}));
      if (rd) chk(16'(req.addr), fd ? 16'h0000 : 16'(r[8:0]));
      @(posedge clk);
      if (i == 40) begin
        rstn <= 0;
        @(negedge clk);
        chk(16'({oe, req.reg_wr, req.fifo_push}), 16'h0000);
      end
      @(posedge clk);
      pins.chip_select_n <= 1'b1;
      if (i == 40) rstn <= 1;
      @(negedge clk);
      s = fd ? fr : rr;
      chk(16'(oe), 16'(rd));
      if (rd) chk(bus, pins.big_endian ? {s[7:0], s[15:8]} : s);
      @(posedge clk);
      @(negedge clk);
      chk(16'({req.reg_wr, req.fifo_push}), 16'({wr & !fd, wr & fd}));
      if (wr) begin
        chk(req.wdata, wq.pop_front());
        chk(16'(req.addr), fd ? 16'h0000 : 16'(r[8:0]));
      end
      @(posedge clk);
      hoe <= 0;
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
